// [ecc_regs.vh]
`ifndef ECC_REGS_VH
`define ECC_REGS_VH
// =====================================
// Phase sequencer
`define ECC_PHASE_W        2
`define ECC_PHASE_ONE      2'h0
`define ECC_PHASE_TWO      2'h1
`define ECC_PHASE_THREE    2'h2
`define ECC_PHASE_FOUR     2'h3
// =====================================
// Counter and prescaler
`define ECC_COUNT_W        8
`define ECC_COUNT_RST      8'h00
`define ECC_PRESC_W        8
`define ECC_PRESC_RST      8'h00
`define ECC_SEL_W          3
// =====================================
// Timing: one internal phase is one core clock
`define ECC_CLK_PERIOD_NS  40
`define ECC_LAT_MIN_PHASES 3
`define ECC_LAT_MAX_PHASES 7
`define ECC_MEAS_ERR_PHASES 4
`endif

// [ecc_ripple_presc.v]
`include "ecc_regs.vh"
// =====================================
// Divide-by-2^(sel+1) ripple-style prescaler
module ecc_ripple_presc (
  input  wire                    clk_in,
  input  wire                    rstn_in,
  input  wire                    pin_in,
  input  wire [`ECC_SEL_W-1:0]   sel_in,
  output reg                     div_out
);
  reg  [`ECC_PRESC_W-1:0] stage_reg;
  reg                     pin_d_reg;
  wire                    rise;
  wire [`ECC_PRESC_W-1:0] stage_next;

  assign rise = pin_in & ~pin_d_reg;
  // Stage 0 toggles on each pin rise, each later stage on the prior stage falling, as a ripple chain would
  assign stage_next = stage_reg + {{(`ECC_PRESC_W-1){1'b0}}, rise};

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage_reg <= `ECC_PRESC_RST;
      pin_d_reg <= 1'b0;
      div_out   <= 1'b0;
    end else begin
      pin_d_reg <= pin_in;
      stage_reg <= stage_next;
      // Any binary stage is a 50 percent square wave
      div_out   <= stage_next[sel_in];
    end
  end
endmodule

// [ecc_event_counter.v]
`include "ecc_regs.vh"
// =====================================
// Operation
// - Bypass feeds pin XOR count_falling_in to synchronizer
// - Sample prescaler output on phases two, four
// - Prescaler divides by ripple, symmetric output
// - Increment 3 to 7 phases after edge
// - Edge interval error within four phases
// - Instruction cycle is four oscillator phases
module ecc_event_counter (
  input  wire                   clk_in,
  input  wire                   rstn_in,
  input  wire                   ext_count_clock_pin_in,
  input  wire                   presc_assign_in,
  input  wire [`ECC_SEL_W-1:0]  presc_sel_in,
  input  wire                   count_falling_in,
  input  wire                   load_in,
  input  wire [`ECC_COUNT_W-1:0] load_value_in,
  output reg  [`ECC_COUNT_W-1:0] event_counter_value_out,
  output reg  [`ECC_PHASE_W-1:0] phase_out,
  output reg                    increment_out
);
  // =====================================
  // One-hot sync states
  localparam [1:0] ST_LOW  = 2'b01;
  localparam [1:0] ST_HIGH = 2'b10;

  reg  [`ECC_PHASE_W-1:0] phase_reg;
  reg  [1:0]              state_reg;
  reg  [1:0]              state_next;
  reg                     sample_reg;
  reg                     edge_reg;
  reg                     edge_next;
  reg                     seed_reg;
  reg                     armed_reg;
  wire                    div_w;
  wire                    presc_out;
  wire                    sample_phase;

  ecc_ripple_presc u_presc (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .pin_in  (ext_count_clock_pin_in),
    .sel_in  (presc_sel_in),
    .div_out (div_w)
  );

  // Pin polarity applied in the bypass path only; the prescaler counts raw pin rises
  assign presc_out = presc_assign_in ? div_w
                   : (ext_count_clock_pin_in ^ count_falling_in);

  function is_sample_phase;
    input [`ECC_PHASE_W-1:0] ph;
    begin
      is_sample_phase = (ph == `ECC_PHASE_TWO) || (ph == `ECC_PHASE_FOUR);
    end
  endfunction

  assign sample_phase = is_sample_phase(phase_reg);

  // =====================================
  // Sync state machine
  always @* begin
    state_next = state_reg;
    edge_next  = 1'b0;
    case (state_reg)
      ST_LOW: begin
        if (sample_reg) begin
          state_next = ST_HIGH;
          // Inverted idle level after reset must not count
          edge_next  = armed_reg;
        end
      end
      ST_HIGH: begin
        if (!sample_reg) begin
          state_next = ST_LOW;
        end
      end
      default: begin
        state_next = ST_LOW;
      end
    endcase
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_reg               <= `ECC_PHASE_ONE;
      sample_reg              <= 1'b0;
      state_reg               <= ST_LOW;
      edge_reg                <= 1'b0;
      seed_reg                <= 1'b0;
      armed_reg               <= 1'b0;
      event_counter_value_out <= `ECC_COUNT_RST;
      phase_out               <= `ECC_PHASE_ONE;
      increment_out           <= 1'b0;
    end else begin
      // Four phases per cycle, wraps naturally
      phase_reg <= phase_reg + 2'h1;
      phase_out <= phase_reg;
      // Sampling only twice per cycle bounds the error
      if (sample_phase) begin
        sample_reg <= presc_out;
        seed_reg   <= 1'b1;
      end
      // First sample only seeds the state machine
      armed_reg <= seed_reg;
      state_reg <= state_next;
      edge_reg  <= edge_next;
      increment_out <= edge_reg;
      // Load wins; an edge pending in the same cycle is dropped, not counted later
      if (load_in) begin
        event_counter_value_out <= load_value_in;
      end else if (edge_reg) begin
        event_counter_value_out <= event_counter_value_out + 8'h01;
      end
    end
  end
endmodule

// [ecc_ext_src.sv]
module ecc_ext_src (
  input  wire  clk_in,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_out = 1'b0;
  // Three clocks high and four low clears 2Tosc+20ns; the prescaler limit is looser
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_in) pin_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      pin_out <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask
endmodule

// [ecc_event_counter_assertions.sv]
module ecc_event_counter_assertions (
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic       ext_count_clock_pin_in,
  input wire logic       presc_assign_in,
  input wire logic       count_falling_in,
  input wire logic       load_in,
  input wire logic [7:0] event_counter_value_out,
  input wire logic [1:0] phase_out,
  input wire logic       increment_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic byp = !presc_assign_in;
  property p_ph; $past(rstn_in, 2) |-> phase_out == $past(phase_out) + 2'h1; endproperty
  a_ph: assert property (p_ph) else $error("phase order");
  property p_step; increment_out && !$past(load_in) |-> event_counter_value_out ==
    $past(event_counter_value_out) + 8'h01; endproperty
  a_step: assert property (p_step) else $error("step not one");
  property p_chg; $changed(event_counter_value_out) && !$past(load_in) |-> increment_out;
  endproperty
  a_chg: assert property (p_chg) else $error("unflagged change");
  property p_one; increment_out |=> !increment_out; endproperty
  a_one: assert property (p_one) else $error("double count");
  property p_rise; byp && !count_falling_in && $rose(ext_count_clock_pin_in) |->
    ##[3:7] increment_out; endproperty
  a_rise: assert property (p_rise) else $error("rise latency");
  property p_fall; byp && count_falling_in && $fell(ext_count_clock_pin_in) |->
    ##[3:7] increment_out; endproperty
  a_fall: assert property (p_fall) else $error("fall latency");
  property p_idle; $stable(ext_count_clock_pin_in)[*8] |-> !increment_out; endproperty
  a_idle: assert property (p_idle) else $error("count w/o edge");
endmodule
bind ecc_event_counter ecc_event_counter_assertions u_chk (.clk_in, .rstn_in,
  .ext_count_clock_pin_in, .presc_assign_in, .count_falling_in, .load_in,
  .event_counter_value_out, .phase_out, .increment_out);

// [ecc_event_counter_tb.sv]
module ecc_event_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rstn_in = 0, asg = 0, fall = 0, load_in = 0;
  logic [2:0] sel = 0;
  logic [7:0] load_v = 0;
  wire pin, inc;
  wire [7:0] cnt;
  wire [1:0] ph;
  int miscompares = 0, n_compared = 0, n_inc = 0;
  // Nibbles: assign, select, falling, pulses; byte: expected count
  logic [23:0] rows [4] = '{24'h0005_05, 24'h0013_03, 24'h1004_02, 24'h1108_02};
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) n_inc <= !rstn_in ? 0 : n_inc + int'(inc);
  ecc_ext_src u_src (.clk_in(clk_in), .pin_out(pin));
  ecc_event_counter u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .ext_count_clock_pin_in(pin),
    .presc_assign_in(asg), .presc_sel_in(sel), .count_falling_in(fall), .load_in(load_in),
    .load_value_in(load_v), .event_counter_value_out(cnt), .phase_out(ph),
    .increment_out(inc));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] a);
    n_compared++;
    if (a !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, a);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (n_compared > 0 && miscompares == 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    print_verdict;
  end
  initial begin
    foreach (rows[i]) begin
      @(posedge clk_in) rstn_in <= 1'b0;
      asg <= rows[i][20];
      sel <= rows[i][18:16];
      fall <= rows[i][12];
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      chk("reset", 8'h00, cnt);
      repeat (2) @(posedge clk_in);
      chk("phase", 8'h01, {6'h00, ph});
      u_src.pulse(int'(rows[i][11:8]));
      repeat (10) @(posedge clk_in);
      chk("count", rows[i][7:0], cnt);
      chk("pulses", rows[i][7:0], n_inc[7:0]);
    end
    // Wrap through 0xff after a load in bypass
    @(posedge clk_in) {asg, fall, load_in, load_v} <= {3'b001, 8'hfe};
    @(posedge clk_in) load_in <= 1'b0;
    @(posedge clk_in);
    chk("load", 8'hfe, cnt);
    u_src.pulse(3);
    repeat (10) @(posedge clk_in);
    chk("wrap", 8'h01, cnt);
    print_verdict;
  end
endmodule
